// File: pkg/rsl_pkg.sv
// Package of constants and types for the receive-skip and link-status registers
`default_nettype none

package rsl_pkg;

	// ------------------------------------------------------------
	// Host pin widths and register selection
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PTR_W = 15;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'hE;
	localparam logic [ADDR_W-1:0] STAT_OFFSET = 4'hF;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_EN_RLINK = 7;
	localparam int CTRL_EN_LLINK = 6;
	localparam int CTRL_EN_BABBLE = 5;
	localparam int CTRL_SKIP = 2;
	localparam int CTRL_EN_SQE = 1;
	localparam int CTRL_FILTER = 0;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h01;
	localparam logic [DATA_W-1:0] CTRL_WMASK = 8'hE3;

	// ------------------------------------------------------------
	// Transceiver status register fields
	// ------------------------------------------------------------
	localparam int STAT_RLINK = 7;
	localparam int STAT_LLINK = 6;
	localparam int STAT_BABBLE = 5;
	localparam int STAT_SIG = 4;
	localparam int STAT_POL = 3;
	localparam int STAT_SQE = 1;
	localparam logic [DATA_W-1:0] STAT_RESET = 8'h00;
	localparam logic [DATA_W-1:0] STAT_W1C_MASK = 8'hFA;
	// Status bits that may raise the interrupt, same positions as their enables
	localparam logic [DATA_W-1:0] IRQ_SRC_MASK = 8'hE2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SKIP_MAX_NS = 300;
	// Longest time rounds down
	localparam int SKIP_MAX_CYC = SKIP_MAX_NS / CLK_PERIOD_NS;
	// Command cycle, load cycle and exit cycle come out of the budget
	localparam int SKIP_WAIT_MAX = SKIP_MAX_CYC - 3;
	localparam int SKIP_CNT_W = 5;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} rsl_host_pins_t;

	localparam rsl_host_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};

	typedef struct packed {
		logic remote_link_fail_flag;
		logic local_link_fail_flag;
		logic remote_babble_flag;
		logic far_end_signalling_flag;
		logic rx_polarity_swap_flag;
		logic sqe_flag;
	} rsl_xcvr_raw_t;

	localparam rsl_xcvr_raw_t XCVR_IDLE = '{default: 1'b0};

	// Skip sequencer, Gray along idle, load, wait
	typedef enum logic [1:0] {
		SKIP_IDLE = 2'h0,
		SKIP_LOAD = 2'h1,
		SKIP_WAIT = 2'h3
	} rsl_skip_state_t;

endpackage

`default_nettype wire

// File: logic/rsl_sync.sv
// Two-stage synchroniser bank for asynchronous pin inputs
`default_nettype none

module rsl_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	// ------------------------------------------------------------
	// Stages; the first is read only by the second
	// ------------------------------------------------------------
	always_comb begin
		next_meta = d_in;
		next_q = meta;
	end

	// Frozen with the rest of the block while the enable is low
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta <= RST_VAL;
			q_out <= RST_VAL;
		end else if (ce_in) begin
			meta <= next_meta;
			q_out <= next_q;
		end
	end

endmodule // rsl_sync

`default_nettype wire

// File: logic/rsl_regs.sv
// Receive packet discard control and transceiver link status registers
`default_nettype none

module rsl_regs #(
	parameter int PTR_W = rsl_pkg::PTR_W
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [rsl_pkg::ADDR_W-1:0] host_addr_in,
	input wire logic [rsl_pkg::DATA_W-1:0] host_data_in,
	output logic [rsl_pkg::DATA_W-1:0] host_data_out,
	output logic host_data_oe_out,
	input wire rsl_pkg::rsl_xcvr_raw_t xcvr_in,
	input wire logic pkt_pending_in,
	input wire logic rd_ready_in,
	input wire logic [PTR_W-1:0] next_pkt_start_in,
	input wire logic [PTR_W-1:0] buf_end_in,
	output logic [PTR_W-1:0] read_ptr_out,
	output logic read_ptr_load_out,
	output logic filter_self_rx_out,
	output logic irq_out
);

	// ------------------------------------------------------------
	// Decode used by both the write and the read paths
	// ------------------------------------------------------------
	function automatic logic hit(input logic [rsl_pkg::ADDR_W-1:0] addr, input logic [rsl_pkg::ADDR_W-1:0] off);
		hit = (addr == off);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	rsl_pkg::rsl_host_pins_t pin_raw;
	rsl_pkg::rsl_host_pins_t pin_s;
	rsl_pkg::rsl_xcvr_raw_t xr_s;

	// Bundle the host pins so they cross together
	always_comb begin
		pin_raw.cs_n = host_cs_n_in;
		pin_raw.rd_n = host_rd_n_in;
		pin_raw.wr_n = host_wr_n_in;
		pin_raw.addr = host_addr_in;
		pin_raw.data = host_data_in;
	end

	rsl_sync #(
		.WIDTH($bits(rsl_pkg::rsl_host_pins_t)),
		.RST_VAL(rsl_pkg::PINS_IDLE)
	) u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.d_in(pin_raw),
		.q_out(pin_s)
	);

	rsl_sync #(
		.WIDTH($bits(rsl_pkg::rsl_xcvr_raw_t)),
		.RST_VAL(rsl_pkg::XCVR_IDLE)
	) u_xcvr_sync (
		.sys_clk_in(sys_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.d_in(xcvr_in),
		.q_out(xr_s)
	);

	// ------------------------------------------------------------
	// Host write capture
	// ------------------------------------------------------------
	rsl_pkg::rsl_host_pins_t pin_q;
	rsl_pkg::rsl_host_pins_t next_pin_q;
	logic wr_commit;
	logic wr_ctrl;
	logic wr_stat;
	logic [rsl_pkg::DATA_W-1:0] wdata;

	// Commit on the trailing edge of the write strobe, using the sample
	// taken while it was still low, since data may vanish right after
	always_comb begin
		next_pin_q = pin_s;
		wr_commit = !pin_q.cs_n && !pin_q.wr_n && pin_s.wr_n;
		wr_ctrl = wr_commit && hit(pin_q.addr, rsl_pkg::CTRL_OFFSET);
		wr_stat = wr_commit && hit(pin_q.addr, rsl_pkg::STAT_OFFSET);
		wdata = pin_q.data;
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_q <= rsl_pkg::PINS_IDLE;
		end else if (ce_in) begin
			pin_q <= next_pin_q;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	logic [rsl_pkg::DATA_W-1:0] ctrl;
	logic [rsl_pkg::DATA_W-1:0] next_ctrl;

	// Enables and filter bit; reserved and command bits are not stored
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = wdata & rsl_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl <= rsl_pkg::CTRL_RESET;
		end else if (ce_in) begin
			ctrl <= next_ctrl;
		end
	end

	// ------------------------------------------------------------
	// Transceiver status flags
	// ------------------------------------------------------------
	logic [rsl_pkg::DATA_W-1:0] stat;
	logic [rsl_pkg::DATA_W-1:0] next_stat;
	logic [rsl_pkg::DATA_W-1:0] set_vec;
	logic [rsl_pkg::DATA_W-1:0] clr_vec;

	// Sticky flags; a set in the clearing cycle wins over the clear.
	// Remote flags only follow the far port while it signals.
	always_comb begin
		set_vec = '0;
		set_vec[rsl_pkg::STAT_RLINK] = xr_s.remote_link_fail_flag && xr_s.far_end_signalling_flag;
		set_vec[rsl_pkg::STAT_LLINK] = xr_s.local_link_fail_flag;
		set_vec[rsl_pkg::STAT_BABBLE] = xr_s.remote_babble_flag && xr_s.far_end_signalling_flag;
		set_vec[rsl_pkg::STAT_SIG] = xr_s.far_end_signalling_flag;
		set_vec[rsl_pkg::STAT_POL] = xr_s.rx_polarity_swap_flag;
		set_vec[rsl_pkg::STAT_SQE] = xr_s.sqe_flag;
		clr_vec = wr_stat ? (wdata & rsl_pkg::STAT_W1C_MASK) : '0;
		next_stat = (stat & ~clr_vec) | set_vec;
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stat <= rsl_pkg::STAT_RESET;
		end else if (ce_in) begin
			stat <= next_stat;
		end
	end

	// ------------------------------------------------------------
	// Packet discard sequencer
	// ------------------------------------------------------------
	rsl_pkg::rsl_skip_state_t skip_state;
	rsl_pkg::rsl_skip_state_t next_skip_state;
	logic [rsl_pkg::SKIP_CNT_W-1:0] skip_cnt;
	logic [rsl_pkg::SKIP_CNT_W-1:0] next_skip_cnt;
	logic [PTR_W-1:0] next_read_ptr;
	logic next_read_ptr_load;
	logic skip_cmd;
	logic skip_busy;

	// The wait is cut off at the limit so the command bit always
	// falls inside its time budget, even if the buffer side stalls
	always_comb begin
		skip_cmd = wr_ctrl && wdata[rsl_pkg::CTRL_SKIP];
		skip_busy = (skip_state != rsl_pkg::SKIP_IDLE);
		next_skip_state = skip_state;
		next_skip_cnt = skip_cnt;
		next_read_ptr = read_ptr_out;
		next_read_ptr_load = 1'b0;
		case (skip_state)
			rsl_pkg::SKIP_IDLE: begin
				if (skip_cmd) begin
					next_skip_state = rsl_pkg::SKIP_LOAD;
				end
			end
			rsl_pkg::SKIP_LOAD: begin
				next_read_ptr = pkt_pending_in ? next_pkt_start_in : buf_end_in;
				next_read_ptr_load = 1'b1;
				next_skip_cnt = '0;
				next_skip_state = rsl_pkg::SKIP_WAIT;
			end
			rsl_pkg::SKIP_WAIT: begin
				next_skip_cnt = skip_cnt + 1'b1;
				if (rd_ready_in || !pkt_pending_in ||
					skip_cnt == rsl_pkg::SKIP_CNT_W'(rsl_pkg::SKIP_WAIT_MAX)) begin
					next_skip_state = rsl_pkg::SKIP_IDLE;
				end
			end
			default: begin
				next_skip_state = rsl_pkg::SKIP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			skip_state <= rsl_pkg::SKIP_IDLE;
			skip_cnt <= '0;
			read_ptr_out <= '0;
			read_ptr_load_out <= 1'b0;
		end else if (ce_in) begin
			skip_state <= next_skip_state;
			skip_cnt <= next_skip_cnt;
			read_ptr_out <= next_read_ptr;
			read_ptr_load_out <= next_read_ptr_load;
		end
	end

	// ------------------------------------------------------------
	// Host read data, filter and interrupt outputs
	// ------------------------------------------------------------
	logic [rsl_pkg::DATA_W-1:0] ctrl_view;
	logic [rsl_pkg::DATA_W-1:0] next_dout;
	logic next_oe;
	logic next_irq;

	// Read data is held between reads so the bus sees a steady value
	always_comb begin
		ctrl_view = ctrl;
		ctrl_view[rsl_pkg::CTRL_SKIP] = skip_busy;
		next_oe = !pin_s.cs_n && !pin_s.rd_n;
		next_dout = host_data_out;
		if (next_oe) begin
			if (hit(pin_s.addr, rsl_pkg::CTRL_OFFSET)) begin
				next_dout = ctrl_view;
			end else if (hit(pin_s.addr, rsl_pkg::STAT_OFFSET)) begin
				next_dout = stat;
			end else begin
				next_dout = '0;
			end
		end
		next_irq = |(stat & ctrl & rsl_pkg::IRQ_SRC_MASK);
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			host_data_out <= '0;
			host_data_oe_out <= 1'b0;
			irq_out <= 1'b0;
			filter_self_rx_out <= 1'b1;
		end else if (ce_in) begin
			host_data_out <= next_dout;
			host_data_oe_out <= next_oe;
			irq_out <= next_irq;
			filter_self_rx_out <= next_ctrl[rsl_pkg::CTRL_FILTER];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);

	localparam int SKIP_LIM = rsl_pkg::SKIP_MAX_CYC;
	logic [rsl_pkg::SKIP_CNT_W:0] busy_age;

	// Enabled cycles spent busy since the command was taken
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_age <= '0;
		end else if (ce_in) begin
			busy_age <= skip_busy ? busy_age + 1'b1 : '0;
		end
	end

	sequence s_skip_cmd;
		ce_in && skip_cmd && !skip_busy;
	endsequence

	sequence s_skip_load;
		ce_in && skip_state == rsl_pkg::SKIP_LOAD;
	endsequence

	property p_skip_start;
		s_skip_cmd |=> s_skip_load ##1 read_ptr_load_out;
	endproperty

	a_skip_start: assert property (p_skip_start) else $error("discard command not started");

	a_skip_budget: assert property (busy_age <= SKIP_LIM) else $error("discard exceeded its time budget");

	a_skip_release: assert property (ce_in && skip_state == rsl_pkg::SKIP_WAIT && (rd_ready_in || !pkt_pending_in)
		|=> !skip_busy) else $error("command bit did not clear when ready");

	a_ptr_choice: assert property (ce_in && skip_state == rsl_pkg::SKIP_LOAD |=> read_ptr_load_out &&
		read_ptr_out == ($past(pkt_pending_in) ? $past(next_pkt_start_in) : $past(buf_end_in)))
		else $error("wrong read pointer after discard");

	a_link_enables: assert property (ce_in && wr_ctrl |=> ctrl[rsl_pkg::CTRL_EN_RLINK:rsl_pkg::CTRL_EN_BABBLE] ==
		$past(wdata[rsl_pkg::CTRL_EN_RLINK:rsl_pkg::CTRL_EN_BABBLE]))
		else $error("link interrupt enables not written");

	a_sqe_enable: assert property (ce_in && wr_ctrl |=> ctrl[rsl_pkg::CTRL_EN_SQE] == $past(wdata[rsl_pkg::CTRL_EN_SQE]))
		else $error("quality error enable not written");

	a_filter_out: assert property (ce_in && wr_ctrl |=> filter_self_rx_out == $past(wdata[rsl_pkg::CTRL_FILTER]))
		else $error("self receive filter output wrong");

	a_w1c_keep: assert property (ce_in |=> ($past(stat) & ~$past(clr_vec) & ~stat) == '0)
		else $error("status flag lost without a clear");

	a_w1c_clear: assert property (ce_in && wr_stat && set_vec == '0 |=> (stat & $past(clr_vec)) == '0)
		else $error("status flag not cleared by write");

	a_local_link: assert property (ce_in && xr_s.local_link_fail_flag |=> stat[rsl_pkg::STAT_LLINK])
		else $error("local link flag not set");

	a_remote_gated: assert property (ce_in && !xr_s.far_end_signalling_flag && !stat[rsl_pkg::STAT_RLINK] &&
		!stat[rsl_pkg::STAT_BABBLE] |=> !stat[rsl_pkg::STAT_RLINK] && !stat[rsl_pkg::STAT_BABBLE])
		else $error("remote flag set without signalling");

	a_signal_track: assert property (ce_in && xr_s.far_end_signalling_flag && xr_s.remote_babble_flag
		|=> stat[rsl_pkg::STAT_SIG] && stat[rsl_pkg::STAT_BABBLE]) else $error("remote flags not tracked");

	a_polarity: assert property (ce_in && xr_s.rx_polarity_swap_flag |=> stat[rsl_pkg::STAT_POL])
		else $error("polarity flag not set");

	a_sqe_flag: assert property (ce_in && xr_s.sqe_flag |=> stat[rsl_pkg::STAT_SQE])
		else $error("quality error flag not set");

	a_irq_hold: assert property (ce_in && (stat & ctrl & rsl_pkg::IRQ_SRC_MASK) != '0 |=> irq_out)
		else $error("interrupt missing for enabled flag");

endmodule // rsl_regs

`default_nettype wire

// File: verif/rsl_bufctl_model.sv
// Buffer controller stand-in that answers the receive discard
`default_nettype none

module rsl_bufctl_model #(
	parameter logic [rsl_pkg::PTR_W-1:0] NEXT_START = 15'h1234,
	parameter logic [rsl_pkg::PTR_W-1:0] DATA_END = 15'h7F00
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic has_pkt_in,
	input wire logic [7:0] delay_in,
	input wire logic load_in,
	input wire logic [rsl_pkg::PTR_W-1:0] ptr_in,
	output logic pkt_pending_out,
	output logic rd_ready_out,
	output logic [rsl_pkg::PTR_W-1:0] next_start_out,
	output logic [rsl_pkg::PTR_W-1:0] data_end_out,
	output logic [rsl_pkg::PTR_W-1:0] got_ptr_out,
	output logic [7:0] load_cnt_out
);
	logic busy;
	logic [7:0] cnt;

	// Stored packet and data end stay steady between discards
	assign pkt_pending_out = has_pkt_in;
	assign next_start_out = NEXT_START;
	assign data_end_out = DATA_END;
	// Ready only after the set delay, so slow answers and the cut-off can be tried
	assign rd_ready_out = busy && (cnt >= delay_in);

	// Ready drops three cycles after rising, so it is never stale at the next discard
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			got_ptr_out <= '0;
			load_cnt_out <= 8'h00;
		end else if (load_in) begin
			busy <= 1'b1;
			cnt <= 8'h00;
			got_ptr_out <= ptr_in;
			load_cnt_out <= load_cnt_out + 8'h01;
		end else if (busy) begin
			if (cnt == delay_in + 8'h02) begin
				busy <= 1'b0;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end
endmodule // rsl_bufctl_model

`default_nettype wire

// File: verif/test_rx_skip_and_link_status_regs.sv
// Self-checking bench for the receive-skip and link-status registers
`default_nettype none

module test_rx_skip_and_link_status_regs;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [rsl_pkg::PTR_W-1:0] NEXT_PKT = 15'h1234;
	localparam logic [rsl_pkg::PTR_W-1:0] DATA_END = 15'h7F00;
	localparam logic [3:0] CTRL = rsl_pkg::CTRL_OFFSET;
	localparam logic [3:0] STAT = rsl_pkg::STAT_OFFSET;
	localparam int FLAG_POS [6] = '{1, 3, 4, 5, 6, 7};

	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	rsl_pkg::rsl_host_pins_t pins = rsl_pkg::PINS_IDLE;
	rsl_pkg::rsl_xcvr_raw_t xcvr = rsl_pkg::XCVR_IDLE;
	logic has_pkt = 1'b0;
	logic [7:0] dly = 8'h00;
	logic [7:0] host_data;
	logic host_oe;
	logic pkt_pending;
	logic rd_ready;
	logic ptr_load;
	logic filter_self_rx;
	logic irq;
	logic [rsl_pkg::PTR_W-1:0] next_start;
	logic [rsl_pkg::PTR_W-1:0] data_end;
	logic [rsl_pkg::PTR_W-1:0] read_ptr;
	logic [rsl_pkg::PTR_W-1:0] got_ptr;
	logic [7:0] load_cnt;
	int fails = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Clock and hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end

	rsl_regs i_dut (
		.sys_clk_in(sys_clk),
		.arst_n_in(arst_n),
		.ce_in(ce),
		.host_cs_n_in(pins.cs_n),
		.host_rd_n_in(pins.rd_n),
		.host_wr_n_in(pins.wr_n),
		.host_addr_in(pins.addr),
		.host_data_in(pins.data),
		.host_data_out(host_data),
		.host_data_oe_out(host_oe),
		.xcvr_in(xcvr),
		.pkt_pending_in(pkt_pending),
		.rd_ready_in(rd_ready),
		.next_pkt_start_in(next_start),
		.buf_end_in(data_end),
		.read_ptr_out(read_ptr),
		.read_ptr_load_out(ptr_load),
		.filter_self_rx_out(filter_self_rx),
		.irq_out(irq)
	);

	rsl_bufctl_model #(.NEXT_START(NEXT_PKT), .DATA_END(DATA_END)) i_bufctl (
		.sys_clk_in(sys_clk),
		.arst_n_in(arst_n),
		.has_pkt_in(has_pkt),
		.delay_in(dly),
		.load_in(ptr_load),
		.ptr_in(read_ptr),
		.pkt_pending_out(pkt_pending),
		.rd_ready_out(rd_ready),
		.next_start_out(next_start),
		.data_end_out(data_end),
		.got_ptr_out(got_ptr),
		.load_cnt_out(load_cnt)
	);

	// ----------------------------------------
	// Host pin tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Strobes held four clocks so the synchronisers see a whole write
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		pins.cs_n = 1'b0;
		pins.wr_n = 1'b0;
		pins.addr = a;
		pins.data = d;
		repeat (4) @(negedge sys_clk);
		pins.wr_n = 1'b1;
		@(negedge sys_clk);
		pins = rsl_pkg::PINS_IDLE;
		repeat (4) @(negedge sys_clk);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(negedge sys_clk);
		pins.cs_n = 1'b0;
		pins.rd_n = 1'b0;
		pins.addr = a;
		repeat (5) @(negedge sys_clk);
		chk(16'(host_oe), 16'h0001, "read drive enable");
		chk(16'(host_data), 16'(exp), what);
		pins = rsl_pkg::PINS_IDLE;
		repeat (4) @(negedge sys_clk);
	endtask

	// Discard, then poll the command bit with a held read until it drops
	task automatic skip_chk(input logic pend, input logic [7:0] d, input logic [rsl_pkg::PTR_W-1:0] ptr);
		logic [7:0] n0;
		logic seen_busy;
		int t;
		n0 = load_cnt;
		has_pkt = pend;
		dly = d;
		seen_busy = 1'b0;
		t = 5;
		bus_wr(CTRL, 8'h05);
		pins.cs_n = 1'b0;
		pins.rd_n = 1'b0;
		pins.addr = CTRL;
		while (t < 45 && !(host_oe === 1'b1 && host_data[2] === 1'b0)) begin
			if (host_oe === 1'b1 && host_data[2] === 1'b1) begin
				seen_busy = 1'b1;
			end
			@(negedge sys_clk);
			t++;
		end
		pins = rsl_pkg::PINS_IDLE;
		repeat (4) @(negedge sys_clk);
		chk(16'(t <= 40), 16'h0001, "discard too slow");
		chk(16'(seen_busy), 16'(pend), "busy seen by polling");
		chk(16'(!pend || t >= 20), 16'h0001, "command bit dropped early");
		chk(16'(load_cnt - n0), 16'h0001, "pointer loads");
		chk(16'(got_ptr), 16'(ptr), "new read pointer");
		rd_chk(CTRL, 8'h01, "control after discard");
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic sig;
		logic [7:0] flg;
		repeat (20) @(negedge sys_clk);
		chk(16'(filter_self_rx), 16'h0001, "filter bit in reset");
		chk(16'(irq), 16'h0000, "irq in reset");
		arst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		rd_chk(CTRL, 8'h01, "control reset");
		rd_chk(STAT, 8'h00, "status reset");
		bus_wr(4'h3, 8'hFF);
		rd_chk(4'h3, 8'h00, "unmapped read");
		bus_wr(CTRL, 8'h1A);
		rd_chk(CTRL, 8'h02, "reserved bits and sqe enable");
		chk(16'(filter_self_rx), 16'h0000, "self receive on");
		bus_wr(CTRL, 8'hE1);
		rd_chk(CTRL, 8'hE1, "link enables");
		chk(16'(filter_self_rx), 16'h0001, "self receive off");
		// Frozen block must ignore both a host write and a flag source
		ce = 1'b0;
		xcvr = rsl_pkg::rsl_xcvr_raw_t'(6'h01);
		bus_wr(CTRL, 8'h00);
		xcvr = rsl_pkg::XCVR_IDLE;
		ce = 1'b1;
		rd_chk(CTRL, 8'hE1, "write while frozen");
		rd_chk(STAT, 8'h00, "flag while frozen");
		// Remote flags count only with the signalling flag up
		xcvr = rsl_pkg::rsl_xcvr_raw_t'(6'h28);
		repeat (8) @(negedge sys_clk);
		xcvr = rsl_pkg::XCVR_IDLE;
		rd_chk(STAT, 8'h00, "remote flags unqualified");
		chk(16'(irq), 16'h0000, "irq without flags");
		// Each flag alone (remote ones with the signalling flag), its own enable only, pulse source then clear
		for (int i = 0; i < 6; i++) begin
			sig = (i == 3 || i == 5);
			flg = 8'(1 << FLAG_POS[i]) | (sig ? 8'h10 : 8'h00);
			bus_wr(CTRL, (8'(1 << FLAG_POS[i]) & 8'hE2) | 8'h01);
			xcvr = rsl_pkg::rsl_xcvr_raw_t'(6'(1 << i) | (sig ? 6'h04 : 6'h00));
			repeat (6) @(negedge sys_clk);
			xcvr = rsl_pkg::XCVR_IDLE;
			repeat (6) @(negedge sys_clk);
			rd_chk(STAT, flg, "flag set");
			chk(16'(irq), 16'(i != 1 && i != 2), "irq held after source drops");
			bus_wr(STAT, 8'h00);
			rd_chk(STAT, flg, "zero write keeps flags");
			bus_wr(STAT, flg);
			rd_chk(STAT, 8'h00, "one write clears flags");
			chk(16'(irq), 16'h0000, "irq after clear");
		end
		bus_wr(CTRL, 8'h01);
		skip_chk(1'b1, 8'h14, NEXT_PKT);
		skip_chk(1'b0, 8'h14, DATA_END);
		skip_chk(1'b1, 8'h64, NEXT_PKT);
		tally_and_finish();
	end
endmodule // test_rx_skip_and_link_status_regs

`default_nettype wire
